//--- rtl/pcc_cfg.svh
// Purpose: offsets, field positions, reset values and limits of the completion cache control
// Assumes: 16-bit configuration registers addressed by byte offset
// Notes: definitions only
`ifndef PCC_CFG_SVH
`define PCC_CFG_SVH
`define PCC_OFF_PF_REQ 8'he8
`define PCC_OFF_XFR 8'hea
`define PCC_OFF_LOWER 8'hec
`define PCC_OFF_UPPER 8'hee
`define PCC_RST_PF_REQ 16'h0443
`define PCC_RST_XFR 16'h0008
`define PCC_RST_LOWER 16'h007f
`define PCC_RST_UPPER 16'h01c0
`define PCC_MASK_PF_REQ 16'h0fcf
`define PCC_MASK_XFR 16'h00ff
`define PCC_MASK_LIM 16'h0fff
`define PCC_CNT_MSB 11
`define PCC_CNT_LSB 8
`define PCC_MODE_MSB 7
`define PCC_MODE_LSB 6
`define PCC_LEN_MSB 3
`define PCC_LEN_LSB 0
`define PCC_CNT_OFF 4'h0
`define PCC_CNT_ONE 4'h1
`define PCC_LEN_MAX 4'h7
`define PCC_MIN_BYTES 14'h0040
`define PCC_MAX_BYTES 14'h2000
`endif

//--- rtl/pcc_pkg.sv
// Purpose: types shared by the completion cache control
// Assumes: constants come from pcc_cfg.svh
// Notes: none
package pcc_pkg;
   typedef enum logic [1:0] {
      PCC_NO_CACHE = 2'b00,
      PCC_LIGHT = 2'b01,
      PCC_FULL = 2'b10,
      PCC_RSVD = 2'b11
   } pcc_policy_t;

   typedef enum logic {PCC_IDLE, PCC_ISSUE} pcc_state_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [1:0] be;
      logic [15:0] wdata;
   } pcc_cfg_req_t;

   typedef struct packed {
      logic valid;
      logic retry;
   } pcc_xfer_t;

   typedef struct packed {
      logic [3:0] prefetch_read_count_limit;
      pcc_policy_t completion_cache_policy;
      logic [3:0] prefetch_byte_length_limit;
      logic [7:0] idle_cycle_start_limit;
      logic [11:0] lower_limit;
      logic [11:0] upper_limit;
   } pcc_cfg_t;
endpackage : pcc_pkg

//--- rtl/pcc_idle_timer.sv
// Purpose: idle counters since the last completion buffer read hit
// Assumes: run is high while completion data is cached
// Notes: expired is registered, one cycle behind the counters
module pcc_idle_timer import pcc_pkg::*; #(
   parameter int CYC_W = 8,
   parameter int CLK_W = 12
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic read_hit,
   input wire logic cycle_start,
   input wire pcc_cfg_t cfg,
   output logic expired
);
   if (CYC_W != 8 || CLK_W != 12) begin : g_chk
      $error("pcc_idle_timer widths must match the register fields");
   end

   logic [CYC_W-1:0] cyc_cnt, next_cyc_cnt;
   logic [CLK_W-1:0] clk_cnt, next_clk_cnt;
   logic next_expired;

   always_comb begin
      next_cyc_cnt = cyc_cnt;
      next_clk_cnt = clk_cnt;
      if (!run || read_hit) begin
         next_cyc_cnt = '0;
         next_clk_cnt = '0;
      end else begin
         if (cycle_start && cyc_cnt != '1) next_cyc_cnt = cyc_cnt + 1'b1;
         if (clk_cnt != '1) next_clk_cnt = clk_cnt + 1'b1;
      end
      // upper limit alone expires it; otherwise both cycle-start and lower limits gate it
      next_expired = run && !read_hit && ((clk_cnt >= cfg.upper_limit) ||
         ((cyc_cnt >= cfg.idle_cycle_start_limit) &&
         (clk_cnt >= cfg.lower_limit)));
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cyc_cnt <= '0;
         clk_cnt <= '0;
         expired <= 1'b0;
      end else begin
         cyc_cnt <= next_cyc_cnt;
         clk_cnt <= next_clk_cnt;
         expired <= next_expired;
      end
   end

   AST_HIT_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
      read_hit |=> (clk_cnt == '0 && cyc_cnt == '0 && !expired))
      else $error("read hit did not restart idle counters");
   AST_XFR_GATE: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(expired) |-> ($past(cyc_cnt) >= cfg.idle_cycle_start_limit || $past(clk_cnt) >= cfg.upper_limit))
      else $error("expired before cycle-start limit");
   AST_LOWER: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(expired) |-> ($past(clk_cnt) >= cfg.lower_limit || $past(clk_cnt) >= cfg.upper_limit))
      else $error("expired before lower clock limit");
   AST_UPPER: assert property (@(posedge clk) disable iff (!rst_n)
      (run && !read_hit && clk_cnt >= cfg.upper_limit) |=> expired)
      else $error("upper limit reached without expiry");
endmodule : pcc_idle_timer

//--- rtl/pcc_ctrl.sv
// Purpose: pre-fetch agent limits, completion cache policy and discard control
// Assumes: all inputs synchronous to clk; cfg requests are single-cycle strobes
// Notes: any of rst_b, link_reset_n, global_reset_n resets every field
`include "pcc_cfg.svh"

module pcc_ctrl import pcc_pkg::*; (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic link_reset_n,
   input wire logic global_reset_n,
   input wire pcc_cfg_req_t cfg_req,
   output logic [15:0] cfg_rdata,
   output logic cfg_rvalid,
   input wire logic thread_start,
   input wire logic pf_ready,
   output logic pf_req,
   output logic [13:0] pf_bytes,
   output logic pf_enabled,
   input wire logic cycle_start,
   input wire logic read_hit,
   input wire pcc_xfer_t xfer_end,
   output logic cache_valid,
   output logic discard
);
   function automatic logic [15:0] merge(input logic [15:0] cur, input logic [1:0] be,
                                         input logic [15:0] wd, input logic [15:0] mask);
      logic [15:0] byte_mask;
      byte_mask = {{8{be[1]}}, {8{be[0]}}};
      merge = ((cur & ~byte_mask) | (wd & byte_mask)) & mask;
   endfunction : merge

   function automatic logic [13:0] len_bytes(input logic [3:0] len);
      len_bytes = (len > `PCC_LEN_MAX) ? `PCC_MAX_BYTES : (`PCC_MIN_BYTES << len[2:0]);
   endfunction : len_bytes

   logic rst_n;
   assign rst_n = rst_b & link_reset_n & global_reset_n;

   logic [15:0] reg_pf_req, reg_xfr, reg_lower, reg_upper;
   logic [15:0] next_reg_pf_req, next_reg_xfr, next_reg_lower, next_reg_upper;
   logic [15:0] next_cfg_rdata;
   logic next_cfg_rvalid;
   pcc_cfg_t cfg;

   // register file
   always_comb begin
      next_reg_pf_req = reg_pf_req;
      next_reg_xfr = reg_xfr;
      next_reg_lower = reg_lower;
      next_reg_upper = reg_upper;
      if (cfg_req.wr) begin
         unique case (cfg_req.addr)
            `PCC_OFF_PF_REQ: next_reg_pf_req = merge(reg_pf_req, cfg_req.be, cfg_req.wdata, `PCC_MASK_PF_REQ);
            `PCC_OFF_XFR: next_reg_xfr = merge(reg_xfr, cfg_req.be, cfg_req.wdata, `PCC_MASK_XFR);
            `PCC_OFF_LOWER: next_reg_lower = merge(reg_lower, cfg_req.be, cfg_req.wdata, `PCC_MASK_LIM);
            `PCC_OFF_UPPER: next_reg_upper = merge(reg_upper, cfg_req.be, cfg_req.wdata, `PCC_MASK_LIM);
            default: ;
         endcase
      end
      next_cfg_rvalid = cfg_req.rd;
      next_cfg_rdata = 16'h0000;
      if (cfg_req.rd) begin
         unique case (cfg_req.addr)
            `PCC_OFF_PF_REQ: next_cfg_rdata = reg_pf_req & `PCC_MASK_PF_REQ;
            `PCC_OFF_XFR: next_cfg_rdata = reg_xfr & `PCC_MASK_XFR;
            `PCC_OFF_LOWER: next_cfg_rdata = reg_lower & `PCC_MASK_LIM;
            `PCC_OFF_UPPER: next_cfg_rdata = reg_upper & `PCC_MASK_LIM;
            default: next_cfg_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_pf_req <= `PCC_RST_PF_REQ;
         reg_xfr <= `PCC_RST_XFR;
         reg_lower <= `PCC_RST_LOWER;
         reg_upper <= `PCC_RST_UPPER;
         cfg_rdata <= 16'h0000;
         cfg_rvalid <= 1'b0;
      end else begin
         reg_pf_req <= next_reg_pf_req;
         reg_xfr <= next_reg_xfr;
         reg_lower <= next_reg_lower;
         reg_upper <= next_reg_upper;
         cfg_rdata <= next_cfg_rdata;
         cfg_rvalid <= next_cfg_rvalid;
      end
   end

   always_comb begin
      cfg.prefetch_read_count_limit = reg_pf_req[`PCC_CNT_MSB:`PCC_CNT_LSB];
      cfg.completion_cache_policy = pcc_policy_t'(reg_pf_req[`PCC_MODE_MSB:`PCC_MODE_LSB]);
      cfg.prefetch_byte_length_limit = reg_pf_req[`PCC_LEN_MSB:`PCC_LEN_LSB];
      cfg.idle_cycle_start_limit = reg_xfr[7:0];
      cfg.lower_limit = reg_lower[11:0];
      cfg.upper_limit = reg_upper[11:0];
   end

   // pre-fetch agent
   pcc_state_t state, next_state;
   logic [3:0] remaining, next_remaining;
   logic next_pf_req, next_pf_enabled, policy_pf;
   logic [13:0] next_pf_bytes;

   always_comb begin
      policy_pf = (cfg.completion_cache_policy == PCC_LIGHT) || (cfg.completion_cache_policy == PCC_FULL);
      next_pf_enabled = policy_pf && (cfg.prefetch_read_count_limit != `PCC_CNT_OFF);
      next_state = state;
      next_remaining = remaining;
      next_pf_req = 1'b0;
      next_pf_bytes = pf_bytes;
      unique case (state)
         PCC_IDLE: begin
            // a new burst reloads the budget; count one issues nothing
            if (thread_start && policy_pf && cfg.prefetch_read_count_limit > `PCC_CNT_ONE) begin
               next_remaining = cfg.prefetch_read_count_limit - 4'h1;
               next_pf_bytes = len_bytes(cfg.prefetch_byte_length_limit);
               next_state = PCC_ISSUE;
            end
         end
         PCC_ISSUE: begin
            if (!policy_pf || cfg.prefetch_read_count_limit <= `PCC_CNT_ONE) begin
               next_state = PCC_IDLE;
            end else if (pf_ready) begin
               next_pf_req = 1'b1;
               next_remaining = remaining - 4'h1;
               if (remaining == 4'h1) next_state = PCC_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= PCC_IDLE;
         remaining <= 4'h0;
         pf_req <= 1'b0;
         pf_bytes <= `PCC_MIN_BYTES;
         pf_enabled <= 1'b0;
      end else begin
         state <= next_state;
         remaining <= next_remaining;
         pf_req <= next_pf_req;
         pf_bytes <= next_pf_bytes;
         pf_enabled <= next_pf_enabled;
      end
   end

   // completion cache keep or discard
   logic expired, keep, next_cache_valid, next_discard;

   pcc_idle_timer #(.CYC_W(8), .CLK_W(12)) u_timer (
      .clk(clk),
      .rst_n(rst_n),
      .run(cache_valid),
      .read_hit(read_hit),
      .cycle_start(cycle_start),
      .cfg(cfg),
      .expired(expired)
   );

   always_comb begin
      unique case (cfg.completion_cache_policy)
         PCC_LIGHT: keep = xfer_end.retry;
         PCC_FULL: keep = 1'b1;
         default: keep = 1'b0;
      endcase
      next_cache_valid = cache_valid;
      next_discard = 1'b0;
      if (xfer_end.valid) begin
         // a fresh keep decision wins over a coincident timer expiry
         next_cache_valid = keep;
         next_discard = !keep;
      end else if (cache_valid && expired) begin
         next_cache_valid = 1'b0;
         next_discard = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cache_valid <= 1'b0;
         discard <= 1'b0;
      end else begin
         cache_valid <= next_cache_valid;
         discard <= next_discard;
      end
   end

   logic [3:0] issued;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) issued <= 4'h0;
      else if (state == PCC_IDLE && thread_start) issued <= 4'h0;
      else if (pf_req) issued <= issued + 4'h1;
   end

   AST_CNT_ZERO_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      (cfg.prefetch_read_count_limit == `PCC_CNT_OFF) |=> !pf_enabled && !pf_req)
      else $error("pre-fetch active with count zero");
   AST_CNT_ONE_NONE: assert property (@(posedge clk) disable iff (!rst_n)
      (cfg.prefetch_read_count_limit == `PCC_CNT_ONE) [*2] |=> !pf_req)
      else $error("pre-fetch issued with count one");
   AST_BURST_BUDGET: assert property (@(posedge clk) disable iff (!rst_n)
      pf_req |-> issued < cfg.prefetch_read_count_limit - 4'h1)
      else $error("too many pre-fetch reads in a burst");
   AST_BURST_START: assert property (@(posedge clk) disable iff (!rst_n)
      (state == PCC_IDLE && thread_start && policy_pf && cfg.prefetch_read_count_limit > `PCC_CNT_ONE)
      |=> state == PCC_ISSUE && remaining == $past(cfg.prefetch_read_count_limit) - 4'h1)
      else $error("burst did not load its pre-fetch budget");
   AST_NO_CACHE_DISCARD: assert property (@(posedge clk) disable iff (!rst_n)
      (xfer_end.valid && cfg.completion_cache_policy == PCC_NO_CACHE) |=> discard && !cache_valid)
      else $error("no-cache mode kept data");
   AST_LIGHT_MASTER: assert property (@(posedge clk) disable iff (!rst_n)
      (xfer_end.valid && !xfer_end.retry && cfg.completion_cache_policy == PCC_LIGHT) |=> discard)
      else $error("light mode kept data after master end");
   AST_RETRY_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
      (xfer_end.valid && xfer_end.retry && policy_pf) |=> cache_valid && !discard)
      else $error("retried data not kept");
   AST_FULL_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
      (xfer_end.valid && cfg.completion_cache_policy == PCC_FULL) |=> cache_valid && !discard)
      else $error("full mode dropped data");
   AST_LEN_BYTES: assert property (@(posedge clk) disable iff (!rst_n)
      (state == PCC_IDLE && next_state == PCC_ISSUE && cfg.prefetch_byte_length_limit == 4'h0)
      |=> pf_bytes == `PCC_MIN_BYTES)
      else $error("wrong pre-fetch length");
   AST_RSVD_READ: assert property (@(posedge clk) disable iff (!rst_n)
      (cfg_req.rd && cfg_req.addr == `PCC_OFF_PF_REQ) |=> cfg_rvalid && cfg_rdata[15:12] == 4'h0
      && cfg_rdata[5:4] == 2'b00)
      else $error("reserved bits read nonzero");
   AST_EXPIRE_DISCARD: assert property (@(posedge clk) disable iff (!rst_n)
      (cache_valid && expired && !xfer_end.valid) |=> discard && !cache_valid)
      else $error("expiry did not discard");
endmodule : pcc_ctrl

//--- tb/pcc_master_model.sv
// Purpose: PCI master side issuing upstream reads to the completion cache control
// Assumes: every output changes at the falling edge of clk
// Notes: pf_ready stalls at random while slow is high
module pcc_master_model import pcc_pkg::*; (
   input wire logic clk,
   input wire logic slow,
   output logic thread_start,
   output logic cycle_start,
   output logic read_hit,
   output pcc_xfer_t xfer_end,
   output logic pf_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      thread_start = 1'b0;
      cycle_start = 1'b0;
      read_hit = 1'b0;
      xfer_end = '0;
      pf_ready = 1'b1;
   end
   always @(negedge clk) begin
      pf_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
   end
   task automatic start_thread();
      @(negedge clk);
      thread_start = 1'b1;
      @(negedge clk);
      thread_start = 1'b0;
   endtask : start_thread
   task automatic end_xfer(input logic retry);
      @(negedge clk);
      xfer_end = '{valid: 1'b1, retry: retry};
      @(negedge clk);
      xfer_end = '0;
   endtask : end_xfer
   task automatic hit();
      read_hit = 1'b1;
      @(negedge clk);
      read_hit = 1'b0;
   endtask : hit
   task automatic starts(input int n);
      repeat (n) begin
         cycle_start = 1'b1;
         @(negedge clk);
      end
      cycle_start = 1'b0;
   endtask : starts
endmodule : pcc_master_model

//--- tb/tb_prefetch_completion_cache_ctrl.sv
// Purpose: self-checking bench for the completion cache control
// Assumes: inputs change at the falling edge of clk
// Notes: register contents mirrored in an integer model
`include "pcc_cfg.svh"
module tb_prefetch_completion_cache_ctrl import pcc_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_b, link_reset_n, global_reset_n, slow;
   pcc_cfg_req_t cfg_req;
   logic [15:0] cfg_rdata, rd;
   logic cfg_rvalid, thread_start, pf_ready, pf_req, pf_enabled;
   logic cycle_start, read_hit, cache_valid, discard;
   logic [13:0] pf_bytes;
   pcc_xfer_t xfer_end;
   int err_total = 0, tests_run = 0, cycles = 0, pf_cnt = 0;
   int mdl[4];
   int msk[4] = '{`PCC_MASK_PF_REQ, `PCC_MASK_XFR, `PCC_MASK_LIM, `PCC_MASK_LIM};
   int dflt[4] = '{`PCC_RST_PF_REQ, `PCC_RST_XFR, `PCC_RST_LOWER, `PCC_RST_UPPER};
   logic [7:0] offs[4] = '{`PCC_OFF_PF_REQ, `PCC_OFF_XFR, `PCC_OFF_LOWER, `PCC_OFF_UPPER};
   pcc_ctrl u_dut (.clk(clk), .rst_b(rst_b), .link_reset_n(link_reset_n), .global_reset_n(global_reset_n),
      .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .thread_start(thread_start),
      .pf_ready(pf_ready), .pf_req(pf_req), .pf_bytes(pf_bytes), .pf_enabled(pf_enabled),
      .cycle_start(cycle_start), .read_hit(read_hit), .xfer_end(xfer_end), .cache_valid(cache_valid),
      .discard(discard));
   pcc_master_model u_master (.clk(clk), .slow(slow), .thread_start(thread_start), .cycle_start(cycle_start),
      .read_hit(read_hit), .xfer_end(xfer_end), .pf_ready(pf_ready));
   initial clk = 1'b0;
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (pf_req === 1'b1) pf_cnt++;
      cycles++;
      if (cycles == 10000) begin
         err_total++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic reg_wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
      int bm;
      bm = {(be[1] ? 8'hff : 8'h00), (be[0] ? 8'hff : 8'h00)};
      @(negedge clk);
      cfg_req = '{wr: 1'b1, rd: 1'b0, addr: a, be: be, wdata: d};
      for (int i = 0; i < 4; i++) if (offs[i] == a) mdl[i] = ((mdl[i] & ~bm) | (d & bm)) & msk[i];
      @(negedge clk);
      cfg_req = '0;
   endtask : reg_wr
   task automatic reg_chk(input logic [7:0] a, input logic [15:0] exp);
      @(negedge clk);
      cfg_req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 2'b11, wdata: 16'h0000};
      @(negedge clk);
      cfg_req = '0;
      check({15'h0000, cfg_rvalid}, 16'h0001);
      check(cfg_rdata, exp);
   endtask : reg_chk
   task automatic all_chk();
      for (int i = 0; i < 4; i++) reg_chk(offs[i], 16'(mdl[i]));
      reg_chk(8'he0, 16'h0000);
   endtask : all_chk
   task automatic pulse_reset(input int which);
      @(negedge clk);
      if (which == 0) rst_b = 1'b0;
      else if (which == 1) link_reset_n = 1'b0;
      else global_reset_n = 1'b0;
      repeat (which == 0 ? 5 : 2) @(negedge clk);
      {rst_b, link_reset_n, global_reset_n} = 3'h7;
      mdl = dflt;
   endtask : pulse_reset
   task automatic rand_wr(input int n);
      repeat (n) reg_wr(offs[$urandom_range(3)], 2'($urandom_range(3)), 16'($urandom));
   endtask : rand_wr
   task automatic burst(input int cnt, input int mode, input int len);
      int exp;
      reg_wr(`PCC_OFF_PF_REQ, 2'b11, 16'((cnt << 8) | (mode << 6) | len));
      @(negedge clk);
      check({15'h0000, pf_enabled}, 16'(cnt != 0 && (mode == 1 || mode == 2)));
      exp = (cnt >= 2 && (mode == 1 || mode == 2)) ? cnt - 1 : 0;
      pf_cnt = 0;
      u_master.start_thread();
      @(negedge clk);
      if (exp > 0) check({2'b00, pf_bytes}, 16'(64 << (len > 7 ? 7 : len)));
      repeat (70) @(negedge clk);
      check(16'(pf_cnt), 16'(exp));
   endtask : burst
   task automatic cache_case(input int mode, input logic retry, input int ns, input int hit_at, input int lim);
      int n;
      logic keep;
      keep = (mode == 2) || (mode == 1 && retry);
      reg_wr(`PCC_OFF_PF_REQ, 2'b11, 16'((4 << 8) | (mode << 6)));
      u_master.end_xfer(retry);
      check({14'h0000, cache_valid, discard}, {14'h0000, keep, !keep});
      if (keep) begin
         u_master.starts(ns);
         n = ns;
         while (discard !== 1'b1 && n < 300) begin
            if (n == hit_at) u_master.hit();
            else @(negedge clk);
            n++;
         end
         check(16'(n >= lim && n <= lim + 5), 16'h0001);
         check({15'h0000, cache_valid}, 16'h0000);
      end
      repeat (3) @(negedge clk);
   endtask : cache_case
   initial begin
      void'($urandom(32'hd9bd));
      // power-on reset low from time zero
      {rst_b, link_reset_n, global_reset_n, slow} = 4'h6;
      cfg_req = '0;
      pulse_reset(0);
      all_chk();
      rand_wr(12);
      all_chk();
      pulse_reset(1);
      all_chk();
      rand_wr(6);
      pulse_reset(2);
      all_chk();
      for (int c = 0; c < 16; c++) begin
         slow = c[0];
         burst(c, 1, c % 9);
      end
      for (int m = 0; m < 4; m++) burst(5, m, m + 4);
      burst(10, 2, 15);
      slow = 1'b0;
      reg_wr(`PCC_OFF_UPPER, 2'h3, 16'h0014);
      for (int m = 0; m < 4; m++) for (int r = 0; r < 2; r++) cache_case(m, r[0], 0, -1, 20);
      reg_wr(`PCC_OFF_XFR, 2'h3, 16'h0003);
      reg_wr(`PCC_OFF_LOWER, 2'h3, 16'h000a);
      reg_wr(`PCC_OFF_UPPER, 2'h3, 16'h003c);
      cache_case(2, 1'b0, 3, -1, 10);
      cache_case(2, 1'b0, 0, -1, 60);
      cache_case(1, 1'b1, 3, 8, 68);
      tally_and_finish();
   end
endmodule : tb_prefetch_completion_cache_ctrl
